// *** charger_pkg.sv ***
// constants and types shared by the charger supervisory logic
// assumes a 50 MHz system clock and an 8-bit register port
package charger_pkg;

  localparam int CLOCK_HZ = 50_000_000;
  localparam int INT_PULSE_US = 256;
  localparam int INT_PULSE_CYCLES = INT_PULSE_US * (CLOCK_HZ / 1_000_000);
  localparam int BLINK_HZ = 1;
  // one tick per half blink period
  localparam int TICK_CYCLES = CLOCK_HZ / (2 * BLINK_HZ);
  localparam int TICKS_PER_HOUR = 3600 * 2 * BLINK_HZ;
  localparam int DEFAULT_MODE_HOURS = 5;
  localparam int LOW_BATTERY_HOURS = 1;
  localparam int USB_TIMER_MINUTES = 45;
  localparam int USB_TIMER_TICKS = USB_TIMER_MINUTES * 60 * 2 * BLINK_HZ;
  localparam int TIMER_W = 18;

  localparam logic [3:0] ADDR_INPUT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CHARGE_CTRL = 4'h1;
  localparam logic [3:0] ADDR_CURRENT_CTRL = 4'h2;
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h5;
  localparam logic [3:0] ADDR_THERMAL_CTRL = 4'h6;
  localparam logic [3:0] ADDR_MISC_CTRL = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_FAULT = 4'h9;

  localparam int HIZ_BIT = 7;
  localparam int CHARGE_CFG_LSB = 4;
  localparam int REDUCED_FORCE_BIT = 0;
  localparam int TERM_ENABLE_BIT = 7;
  localparam int EARLY_DONE_BIT = 6;
  localparam int TIMER_ENABLE_BIT = 3;
  localparam int DURATION_LSB = 1;
  localparam int THERMAL_SEL_LSB = 0;
  localparam int SLOW_ENABLE_BIT = 6;
  localparam int PHASE_LSB = 4;
  localparam int REGULATION_BIT = 3;
  localparam int THERMAL_REG_BIT = 1;
  localparam int DEFAULT_MODE_BIT = 7;
  localparam int FAULT_CODE_LSB = 4;

  localparam logic HIZ_RST = 1'b0;
  localparam logic [1:0] CHARGE_CFG_RST = 2'h1;
  localparam logic REDUCED_FORCE_RST = 1'b0;
  localparam logic TERM_ENABLE_RST = 1'b1;
  localparam logic EARLY_DONE_RST = 1'b0;
  localparam logic TIMER_ENABLE_RST = 1'b1;
  localparam logic [1:0] DURATION_RST = 2'h1;
  localparam logic [1:0] THERMAL_SEL_RST = 2'h3;
  localparam logic SLOW_ENABLE_RST = 1'b1;

  localparam logic [1:0] CFG_DISABLE = 2'h0;
  localparam logic [1:0] CFG_CHARGE = 2'h1;

  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_INPUT_OV = 2'h1;
  localparam logic [1:0] FAULT_THERMAL = 2'h2;
  localparam logic [1:0] FAULT_TIMER = 2'h3;

  // order gives the status field codes 00..11
  typedef enum logic [1:0] {PH_DISABLED, PH_PRECHARGE, PH_FAST, PH_DONE} phase_t;

endpackage

// *** tick_divider.sv ***
// free-running divider giving a one-cycle tick every CYCLES clocks
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] count;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count >= 32'(CYCLES - 1)) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** charge_supervisor.sv ***
// charge termination, safety and usb timers, status pins, interrupt and fault register
// assumes synchronous comparator inputs and a one-cycle register port with read data a cycle later
// Notes on behaviour
// R01: end charge when full voltage and low current
// R02: termination sets phase 11 and interrupts
// R03: no termination during regulation or when disabled
// R04: host disables termination under reduced current
// R05: early done raises status below 800 mA
// R06: default mode: 5 h timer sets high impedance
// R07: host mode: programmed timer clears high impedance
// R08: low battery uses 1 h timer
// R09: timer expiry sets fault 11 and interrupts
// R10: timer enable bit gates the safety timer
// R11: four events restart the safety timer
// R12: half-rate counting during regulation or reduced current
// R13: host disables timer before changing configuration
// R14: default-mode 100 mA source has 45 min timer
// R15: input good low only for good source
// R16: status low charging, high idle, blinks on fault
// R17: 256 us interrupt pulse on listed events
// R18: fault latched until read, interrupts held meanwhile
// R19: first fault read latched, second live
// R20: thermal regulation cuts current, sets status bit
// R21: thermal shutdown stops converter, fault 10
// R22: input overvoltage stops switching, fault 01
// R23: phase codes disabled, precharge, fast, done
// R24: timers count a common prescaled tick
`timescale 1ns/1ps
`default_nettype none
module charge_supervisor #(
  parameter int TICK_PERIOD = charger_pkg::TICK_CYCLES,
  parameter int PULSE_CYCLES = charger_pkg::INT_PULSE_CYCLES,
  parameter int HOURS_CODE0 = 4,
  parameter int HOURS_CODE1 = 8,
  parameter int HOURS_CODE2 = 12,
  parameter int HOURS_CODE3 = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic watchdogExpired,
  input wire logic chargeEnablePin_n,
  input wire logic aboveUndervoltageLockout,
  input wire logic aboveBattery,
  input wire logic notPoorSource,
  input wire logic sourceIdentified,
  input wire logic usb100Source,
  input wire logic abovePrechargeLevel,
  input wire logic belowLowBatteryThreshold,
  input wire logic aboveRechargeThreshold,
  input wire logic belowTerminationCurrent,
  input wire logic belowEarlyDoneCurrent,
  input wire logic inputCurrentRegulation,
  input wire logic thermalRegulation,
  input wire logic thermalShutdown,
  input wire logic inputOvervoltage,
  output logic inputGoodOutput_n,
  output logic chargeStatusOutput,
  output logic hostInterrupt,
  output logic converterEnable,
  output logic batterySwitchOn,
  output logic reduceChargeCurrent,
  output logic [1:0] thermalLimitSelect
);
  import charger_pkg::*;

  localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);
  localparam int ONE_HOUR = LOW_BATTERY_HOURS * TICKS_PER_HOUR;

  logic high_impedance_state, reducedForce, termEnable, earlyDone, timerEnable, slowEnable, hostMode;
  logic [1:0] chargeCfg, duration, thermalSel;
  phase_t phase, next_phase;
  logic tick, halfPhase, timerFault, cePrev, blink;
  logic [TIMER_W-1:0] safetyCount, usbCount, limit;
  logic [1:0] faultLatch, liveFault;
  logic [PULSE_W-1:0] intCount;
  logic goodPrev, uvloPrev, sourcePrev;

  wire writeInput = regWrite && regAddr == ADDR_INPUT_CTRL;
  wire writeCharge = regWrite && regAddr == ADDR_CHARGE_CTRL;
  wire writeTimer = regWrite && regAddr == ADDR_TIMER_CTRL;
  wire faultRead = regRead && regAddr == ADDR_FAULT;
  wire charging = phase == PH_PRECHARGE || phase == PH_FAST;
  wire regulating = inputCurrentRegulation || thermalRegulation;
  wire inputGood = aboveUndervoltageLockout && aboveBattery && !inputOvervoltage && notPoorSource;
  wire chargeAllowed = chargeCfg == CFG_CHARGE && !chargeEnablePin_n && !high_impedance_state && !timerFault
    && inputGood && !thermalShutdown;
  wire terminate = phase == PH_FAST && aboveRechargeThreshold && belowTerminationCurrent
    && termEnable && !regulating && chargeAllowed;
  wire cycleStart = !charging && (next_phase == PH_PRECHARGE || next_phase == PH_FAST);
  wire ceToggle = chargeEnablePin_n && !cePrev;
  wire cfgEnable = writeCharge && chargeCfg == CFG_DISABLE
    && regWriteData[CHARGE_CFG_LSB +: 2] == CFG_CHARGE;
  wire timerEnRise = writeTimer && !timerEnable && regWriteData[TIMER_ENABLE_BIT];
  wire restart = cycleStart || ceToggle || cfgEnable || timerEnRise;
  wire slow = slowEnable && (regulating || reducedForce);
  wire accept = tick && (!slow || halfPhase);
  wire expire = timerEnable && charging && !restart && accept && safetyCount + 1'b1 >= limit;
  wire usbRun = !hostMode && usb100Source && charging;
  wire usbExpire = usbRun && tick && usbCount + 1'b1 >= TIMER_W'(USB_TIMER_TICKS);
  wire faultCapture = faultLatch == FAULT_NONE && liveFault != FAULT_NONE;
  wire intEvent = terminate || expire || faultCapture || (sourceIdentified && !sourcePrev)
    || (inputGood && !goodPrev) || (!aboveUndervoltageLockout && uvloPrev);

  tick_divider #(
    .CYCLES(TICK_PERIOD)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick) // R24
  );

  // plain control bits written by software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chargeCfg <= CHARGE_CFG_RST;
      reducedForce <= REDUCED_FORCE_RST;
      termEnable <= TERM_ENABLE_RST;
      earlyDone <= EARLY_DONE_RST;
      timerEnable <= TIMER_ENABLE_RST;
      duration <= DURATION_RST;
      thermalSel <= THERMAL_SEL_RST;
      slowEnable <= SLOW_ENABLE_RST;
    end else if (regWrite) begin
      unique case (regAddr)
        ADDR_CHARGE_CTRL: chargeCfg <= regWriteData[CHARGE_CFG_LSB +: 2];
        ADDR_CURRENT_CTRL: reducedForce <= regWriteData[REDUCED_FORCE_BIT];
        ADDR_TIMER_CTRL: begin
          termEnable <= regWriteData[TERM_ENABLE_BIT];
          earlyDone <= regWriteData[EARLY_DONE_BIT];
          timerEnable <= regWriteData[TIMER_ENABLE_BIT]; // R10
          duration <= regWriteData[DURATION_LSB +: 2];
        end
        ADDR_THERMAL_CTRL: thermalSel <= regWriteData[THERMAL_SEL_LSB +: 2];
        ADDR_MISC_CTRL: slowEnable <= regWriteData[SLOW_ENABLE_BIT];
        default: ;
      endcase
    end
  end

  // any write enters host mode, watchdog expiry returns to default mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hostMode <= 1'b0;
    end else if (regWrite) begin
      hostMode <= 1'b1;
    end else if (watchdogExpired) begin
      hostMode <= 1'b0;
    end
  end

  // high impedance: hardware events win over a software write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      high_impedance_state <= HIZ_RST;
    end else if ((expire && !hostMode) || usbExpire) begin
      high_impedance_state <= 1'b1; // R06 R14
    end else if (expire && hostMode) begin
      high_impedance_state <= 1'b0; // R07
    end else if (writeInput) begin
      high_impedance_state <= regWriteData[HIZ_BIT];
    end
  end

  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_DISABLED: if (chargeAllowed) next_phase = abovePrechargeLevel ? PH_FAST : PH_PRECHARGE;
      PH_PRECHARGE: begin
        if (!chargeAllowed) next_phase = PH_DISABLED;
        else if (abovePrechargeLevel) next_phase = PH_FAST;
      end
      PH_FAST: begin
        if (!chargeAllowed) next_phase = PH_DISABLED;
        else if (terminate) next_phase = PH_DONE; // R01 R03
      end
      PH_DONE: begin
        if (!chargeAllowed) next_phase = PH_DISABLED;
        else if (!aboveRechargeThreshold) next_phase = abovePrechargeLevel ? PH_FAST : PH_PRECHARGE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_DISABLED;
    end else begin
      phase <= next_phase; // R02 R23
    end
  end

  // safety timer limit in ticks
  always_comb begin
    int hours;
    hours = DEFAULT_MODE_HOURS;
    if (hostMode) begin
      unique case (duration)
        2'h0: hours = HOURS_CODE0;
        2'h1: hours = HOURS_CODE1;
        2'h2: hours = HOURS_CODE2;
        2'h3: hours = HOURS_CODE3;
      endcase
    end
    limit = TIMER_W'(hours * TICKS_PER_HOUR); // R06 R07
    if (belowLowBatteryThreshold) limit = TIMER_W'(ONE_HOUR); // R08
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cePrev <= 1'b1;
    end else begin
      cePrev <= chargeEnablePin_n;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      halfPhase <= 1'b0;
    end else if (restart) begin
      halfPhase <= 1'b0;
    end else if (tick && slow) begin
      halfPhase <= !halfPhase; // R12
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      safetyCount <= '0;
    end else if (restart || !timerEnable || expire) begin
      safetyCount <= '0; // R11
    end else if (charging && accept) begin
      safetyCount <= safetyCount + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timerFault <= 1'b0;
    end else if (expire) begin
      timerFault <= 1'b1; // R09
    end else if (restart || !timerEnable) begin
      timerFault <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      usbCount <= '0;
    end else if (!usbRun || usbExpire) begin
      usbCount <= '0;
    end else if (tick) begin
      usbCount <= usbCount + 1'b1; // R14
    end
  end

  always_comb begin
    liveFault = FAULT_NONE;
    if (inputOvervoltage) liveFault = FAULT_INPUT_OV; // R22
    else if (thermalShutdown) liveFault = FAULT_THERMAL; // R21
    else if (timerFault) liveFault = FAULT_TIMER; // R09
  end

  // fault latch: a read reloads it from the live state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      faultLatch <= FAULT_NONE;
    end else if (faultRead) begin
      faultLatch <= liveFault; // R19
    end else if (faultCapture) begin
      faultLatch <= liveFault; // R18
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      goodPrev <= 1'b0;
      uvloPrev <= 1'b0;
      sourcePrev <= 1'b0;
    end else begin
      goodPrev <= inputGood;
      uvloPrev <= aboveUndervoltageLockout;
      sourcePrev <= sourceIdentified;
    end
  end

  // interrupt pulse, retriggered by each event
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      intCount <= '0;
      hostInterrupt <= 1'b0;
    end else if (intEvent) begin
      intCount <= PULSE_W'(PULSE_CYCLES - 1);
      hostInterrupt <= 1'b1; // R17
    end else if (intCount != '0) begin
      intCount <= intCount - 1'b1;
    end else begin
      hostInterrupt <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blink <= 1'b1;
    end else if (liveFault == FAULT_NONE) begin
      blink <= 1'b1;
    end else if (tick) begin
      blink <= !blink;
    end
  end

  // pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inputGoodOutput_n <= 1'b1;
      chargeStatusOutput <= 1'b1;
      converterEnable <= 1'b0;
      batterySwitchOn <= 1'b0;
      reduceChargeCurrent <= 1'b0;
      thermalLimitSelect <= THERMAL_SEL_RST;
    end else begin
      inputGoodOutput_n <= !inputGood; // R15
      if (liveFault != FAULT_NONE) chargeStatusOutput <= blink; // R16
      else if (earlyDone && phase == PH_FAST && belowEarlyDoneCurrent) chargeStatusOutput <= 1'b1; // R05
      else chargeStatusOutput <= !charging;
      converterEnable <= !high_impedance_state && !inputOvervoltage && !thermalShutdown; // R21 R22
      batterySwitchOn <= charging;
      reduceChargeCurrent <= thermalRegulation; // R20
      thermalLimitSelect <= thermalSel;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regReadData <= 8'h00;
    end else if (!regRead) begin
      regReadData <= 8'h00;
    end else begin
      unique case (regAddr)
        ADDR_INPUT_CTRL: regReadData <= 8'(high_impedance_state) << HIZ_BIT;
        ADDR_CHARGE_CTRL: regReadData <= 8'(chargeCfg) << CHARGE_CFG_LSB;
        ADDR_CURRENT_CTRL: regReadData <= 8'(reducedForce) << REDUCED_FORCE_BIT;
        ADDR_TIMER_CTRL: regReadData <= (8'(termEnable) << TERM_ENABLE_BIT)
          | (8'(earlyDone) << EARLY_DONE_BIT) | (8'(timerEnable) << TIMER_ENABLE_BIT)
          | (8'(duration) << DURATION_LSB);
        ADDR_THERMAL_CTRL: regReadData <= 8'(thermalSel) << THERMAL_SEL_LSB;
        ADDR_MISC_CTRL: regReadData <= 8'(slowEnable) << SLOW_ENABLE_BIT;
        ADDR_STATUS: regReadData <= (8'(phase) << PHASE_LSB) // R02
          | (8'(regulating) << REGULATION_BIT) | (8'(thermalRegulation) << THERMAL_REG_BIT); // R20
        ADDR_FAULT: regReadData <= (8'(!hostMode) << DEFAULT_MODE_BIT)
          | (8'(faultLatch) << FAULT_CODE_LSB); // R19
        default: regReadData <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_term_done: assert property (terminate |=> phase == PH_DONE ##[1:3] hostInterrupt) // R02
    else $error("termination did not reach done with interrupt");
  a_term_blocked: assert property (phase == PH_FAST && (regulating || !termEnable) |=> phase != PH_DONE) // R03
    else $error("termination during regulation or when disabled");
  a_default_hiz: assert property (expire && !hostMode |=> high_impedance_state ##1 !converterEnable) // R06
    else $error("default-mode expiry did not stop converter");
  a_host_hiz: assert property (expire && hostMode && !writeInput |=> !high_impedance_state) // R07
    else $error("host-mode expiry left high impedance set");
  a_low_batt: assert property (belowLowBatteryThreshold |-> limit == TIMER_W'(ONE_HOUR)) // R08
    else $error("low battery limit not one hour");
  a_timer_fault: assert property (expire && !inputOvervoltage && !thermalShutdown |=> liveFault == FAULT_TIMER) // R09
    else $error("expiry without timer fault");
  a_timer_off: assert property (!timerEnable |-> !expire) // R10
    else $error("expiry while timer disabled");
  a_timer_restart: assert property (restart |=> safetyCount == '0 && !timerFault) // R11
    else $error("restart did not clear safety timer");
  a_half_rate: assert property (slow && tick && !halfPhase && !restart && charging |=> $stable(safetyCount)) // R12
    else $error("timer counted a skipped tick");
  a_good_pin: assert property ($past(rst_n) |-> inputGoodOutput_n == !$past(inputGood)) // R15
    else $error("input good pin mismatch");
  a_stat_charging: assert property (charging && liveFault == FAULT_NONE && !earlyDone |=> !chargeStatusOutput) // R16
    else $error("status pin high while charging");
  a_int_pulse: assert property ($rose(hostInterrupt) |-> hostInterrupt [*8]) // R17
    else $error("interrupt pulse too short");
  a_fault_hold: assert property (faultLatch != FAULT_NONE && !faultRead |=> $stable(faultLatch)) // R18
    else $error("latched fault changed before read");
  a_fault_read: assert property (faultRead |=> regReadData[FAULT_CODE_LSB +: 2] == $past(faultLatch)) // R19
    else $error("fault read did not return latched code");
  a_overvolt: assert property (inputOvervoltage |=> !converterEnable && faultLatch != FAULT_NONE) // R22
    else $error("overvoltage did not stop converter");

  c_terminate: cover property (terminate ##1 phase == PH_DONE);
  c_expire_host: cover property (hostMode && expire);
  c_usb_expire: cover property (usbExpire);
  c_fault_twice: cover property (faultRead ##1 faultRead);
endmodule
`default_nettype wire

// *** host_model.sv ***
// host side model: register port master and interrupt pulse monitor
// assumes the one-cycle register port of the charge supervisor
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clock,
  input wire logic hostInterrupt,
  input wire logic [7:0] regReadData,
  output var logic [3:0] regAddr,
  output var logic [7:0] regWriteData,
  output var logic regWrite,
  output var logic regRead,
  output var logic [15:0] intCount,
  output var logic [15:0] lastWidth
);
  logic [15:0] width;

  initial begin
    regAddr = 4'h0;
    regWriteData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    intCount = 16'h0000;
    lastWidth = 16'h0000;
    width = 16'h0000;
  end

  // counts pulses at their rise, keeps the length of the last one
  always @(posedge clock) begin
    if (hostInterrupt === 1'b1) begin
      width <= width + 16'h0001;
      if (width == 16'h0000) begin
        intCount <= intCount + 16'h0001;
      end
    end else if (width != 16'h0000) begin
      lastWidth <= width;
      width <= 16'h0000;
    end
  end

  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    d = regReadData;
  endtask
endmodule
`default_nettype wire

// *** charge_timer_status_fault_logic_tb_top.sv ***
// self-checking bench for the charge supervisor
// assumes host_model drives the register port; short tick and pulse counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module charge_timer_status_fault_logic_tb_top;
  import charger_pkg::*;
  localparam int TP = 4;
  localparam int PC = 16;
  logic clock, rst_n, regWrite, regRead, hostInterrupt, converterEnable;
  logic [3:0] regAddr;
  logic [7:0] regWriteData, regReadData, rd;
  logic [15:0] intCount, lastWidth, n0;
  logic wdog, ceN, undervoltage_lockout, aboveBat, notPoor, srcId, usb, preLvl, lowBat;
  logic recharge, termCur, earlyCur, inReg, thReg, tsd, ov;
  logic pgN, stat, batSw, reduceCur, seen;
  logic [1:0] thSel;
  int errors = 0;
  int checked = 0;
  int n;
  logic [3:0] addrs [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [7:0] exps [9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h8A, 8'h03, 8'h40, 8'h20, 8'h80};

  charge_supervisor #(.TICK_PERIOD(TP), .PULSE_CYCLES(PC)) i_dut (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .watchdogExpired(wdog), .chargeEnablePin_n(ceN), .aboveUndervoltageLockout(undervoltage_lockout),
    .aboveBattery(aboveBat), .notPoorSource(notPoor), .sourceIdentified(srcId),
    .usb100Source(usb), .abovePrechargeLevel(preLvl), .belowLowBatteryThreshold(lowBat),
    .aboveRechargeThreshold(recharge), .belowTerminationCurrent(termCur),
    .belowEarlyDoneCurrent(earlyCur), .inputCurrentRegulation(inReg),
    .thermalRegulation(thReg), .thermalShutdown(tsd), .inputOvervoltage(ov),
    .inputGoodOutput_n(pgN), .chargeStatusOutput(stat), .hostInterrupt(hostInterrupt),
    .converterEnable(converterEnable), .batterySwitchOn(batSw),
    .reduceChargeCurrent(reduceCur), .thermalLimitSelect(thSel));

  host_model i_host (
    .clock(clock), .hostInterrupt(hostInterrupt), .regReadData(regReadData),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .intCount(intCount), .lastWidth(lastWidth));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic stop_test();
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  // sel 0: interrupt rise, sel 1: converter stop
  task automatic wait_sig(input int sel, input int lim, output int cnt);
    cnt = 0;
    while (((sel == 0) ? hostInterrupt !== 1'b1 : converterEnable !== 1'b0) && cnt < lim) begin
      @(posedge clock);
      cnt++;
    end
    if (cnt >= lim) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    i_host.read_reg(a, rd);
    `CHK(rd, e)
  endtask

  initial begin
    rst_n = 1'b0;
    {wdog, ceN, srcId, usb, lowBat, recharge, termCur, earlyCur, inReg, thReg, tsd, ov} = 12'h000;
    {undervoltage_lockout, aboveBat, notPoor, preLvl} = 4'hF;
    cyc(5);
    rst_n <= 1'b1;
    cyc(30);
    for (int i = 0; i < 9; i++) begin
      i_host.read_reg(addrs[i], rd);
      `CHK(rd, exps[i])
    end
    `CHK(pgN, 1'b0)
    `CHK(stat, 1'b0)
    `CHK(thSel, 2'h3)
    n0 = intCount;
    srcId <= 1'b1;
    cyc(30);
    `CHK(intCount, n0 + 16'h0001)
    `CHK(lastWidth, 16'(PC))
    notPoor <= 1'b0;
    cyc(3);
    `CHK(pgN, 1'b1)
    notPoor <= 1'b1;
    cyc(30);
    `CHK(intCount, n0 + 16'h0002)
    i_host.write_reg(ADDR_TIMER_CTRL, 8'h0A);
    recharge <= 1'b1;
    termCur <= 1'b1;
    inReg <= 1'b1;
    rd_chk(ADDR_STATUS, 8'h28);
    i_host.write_reg(ADDR_TIMER_CTRL, 8'h8A);
    rd_chk(ADDR_STATUS, 8'h28);
    inReg <= 1'b0;
    thReg <= 1'b1;
    rd_chk(ADDR_STATUS, 8'h2A);
    `CHK(reduceCur, 1'b1)
    n0 = intCount;
    thReg <= 1'b0;
    cyc(30);
    rd_chk(ADDR_STATUS, 8'h30);
    `CHK(intCount, n0 + 16'h0001)
    `CHK(stat, 1'b1)
    `CHK(batSw, 1'b0)
    recharge <= 1'b0;
    termCur <= 1'b0;
    rd_chk(ADDR_STATUS, 8'h20);
    i_host.write_reg(ADDR_TIMER_CTRL, 8'hCA);
    earlyCur <= 1'b1;
    cyc(3);
    `CHK(stat, 1'b1)
    rd_chk(ADDR_STATUS, 8'h20);
    earlyCur <= 1'b0;
    i_host.write_reg(ADDR_TIMER_CTRL, 8'h8A);
    cyc(3);
    `CHK(stat, 1'b0)
    n0 = intCount;
    ov <= 1'b1;
    cyc(3);
    `CHK(converterEnable, 1'b0)
    `CHK(intCount, n0 + 16'h0001)
    seen = 1'b0;
    rd[0] = stat;
    for (int i = 0; i < 3 * TP; i++) begin
      cyc(1);
      seen = seen | (stat !== rd[0]);
    end
    `CHK(seen, 1'b1)
    tsd <= 1'b1;
    cyc(30);
    `CHK(intCount, n0 + 16'h0001)
    ov <= 1'b0;
    cyc(30);
    `CHK(converterEnable, 1'b0)
    rd_chk(ADDR_FAULT, 8'h10);
    tsd <= 1'b0;
    rd_chk(ADDR_FAULT, 8'h20);
    rd_chk(ADDR_FAULT, 8'h00);
    lowBat <= 1'b1;
    i_host.write_reg(ADDR_TIMER_CTRL, 8'h02);
    i_host.write_reg(ADDR_CURRENT_CTRL, 8'h01);
    i_host.write_reg(ADDR_TIMER_CTRL, 8'h0A);
    wait_sig(0, 60000, n);
    `CHK((n >= 57400 && n <= 57800), 1'b1)
    rd_chk(ADDR_FAULT, 8'h30);
    `CHK(converterEnable, 1'b1)
    lowBat <= 1'b0;
    i_host.write_reg(ADDR_TIMER_CTRL, 8'h02);
    i_host.write_reg(ADDR_CURRENT_CTRL, 8'h00);
    rd_chk(ADDR_FAULT, 8'h30);
    wdog <= 1'b1;
    cyc(1);
    wdog <= 1'b0;
    usb <= 1'b1;
    wait_sig(1, 23000, n);
    `CHK((n >= 21000 && n <= 21700), 1'b1)
    rd_chk(ADDR_INPUT_CTRL, 8'h80);
    usb <= 1'b0;
    i_host.write_reg(ADDR_INPUT_CTRL, 8'h00);
    cyc(3);
    `CHK(converterEnable, 1'b1)
    stop_test();
  end
endmodule
`default_nettype wire
